// ==== verilog/fpcs_defines.vh ====
// Constants for the flash protection command and status host controller
`ifndef FPCS_DEFINES_VH
`define FPCS_DEFINES_VH
// Avalon register word addresses
`define FPCS_REG_CTRL     3'h0
`define FPCS_REG_ADDR     3'h1
`define FPCS_REG_DATA     3'h2
`define FPCS_REG_STATUS   3'h3
`define FPCS_REG_RDATA    3'h4
// Command codes written to CTRL[3:0]
`define FPCS_CMD_LOCK_PROG   4'h1
`define FPCS_CMD_LOCK_ERASE  4'h2
`define FPCS_CMD_PWD_PROG    4'h3
`define FPCS_CMD_LOCK_STATUS 4'h4
`define FPCS_CMD_POLL        4'h5
`define FPCS_CMD_RESET       4'h6
`define FPCS_CMD_WRITE       4'h7
`define FPCS_CMD_READ        4'h8
// CTRL field positions
`define FPCS_CTRL_GO      4
// Lock location low address bytes
`define FPCS_LOC_SECURE   8'h1A
`define FPCS_LOC_PASSWORD 8'h0A
`define FPCS_LOC_PERSIST  8'h12
`define FPCS_LOC_SECTOR   8'h02
// Command bus values
`define FPCS_UNLOCK_A1    12'h555
`define FPCS_UNLOCK_A2    12'h2AA
`define FPCS_UNLOCK_D1    8'hAA
`define FPCS_UNLOCK_D2    8'h55
`define FPCS_OP_LOCK      8'h60
`define FPCS_OP_LOCK_PROG 8'h68
`define FPCS_OP_LOCK_VFY  8'h48
`define FPCS_OP_LOCK_ERA  8'h60
`define FPCS_OP_ERA_VFY   8'h40
`define FPCS_OP_PWD_PROG  8'h38
`define FPCS_OP_LBS       8'h58
`define FPCS_OP_IDQUERY   8'h90
`define FPCS_OP_RESET     8'hF0
// Bit positions on the data bus
`define FPCS_BIT_LOWEST   0
`define FPCS_BIT_SECOND   1
`define FPCS_BIT_TIMEOUT  5
`define FPCS_BIT_TOGGLE   6
`define FPCS_BIT_POLL     7
// Timing: 200 MHz clock, times in ns
`define FPCS_CLK_NS       5
`define FPCS_LOCK_WAIT_NS 100000
`define FPCS_PWD_WAIT_NS  2000
`define FPCS_STROBE_CYC   4'h4
`define FPCS_MAX_TRIES    8'hFF
`endif

// ==== verilog/fpcs_host.v ====
// Host controller issuing protection commands and polling status
//
// Design decisions made here: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "fpcs_defines.vh"

// How it works
// R1: Secure and password lock bytes 1A, 0A
// R2: Persistent mode 12, sector lock 02
// R3: Unlock cycles drive only low address/data
// R4: Lock program verify lowest line, retry
// R5: Wait 100 us before verify cycle
// R6: Wait 2 us between password portions
// R7: Password portions at word 0-3, full sequence
// R8: Password verify returns FF once locked
// R9: Erase-all verifies lowest line zero, retry
// R10: Lock status on second data line
// R11: ID query opener then reset after locking
// R12: Polling bit inverted while programming
// R13: Protected program busy about 1 us
// R14: Erase polling reads 0 until done
// R15: All-protected erase busy about 400 us
// R16: Full data valid only on next read
// R17: Ready/busy low while program or erase
// R18: Toggle bit inverts each read when busy
// R19: Toggle briefly for protected targets
// R20: Toggle stops in erase suspend
// R21: Recheck polling after timeout bit high
// R22: Status valid after final write strobe
// R23: Still toggling after timeout means fail
// R24: No new lock command while bank busy
module fpcs_host #(
    parameter LOCK_WAIT_CYC = (`FPCS_LOCK_WAIT_NS + `FPCS_CLK_NS - 1) / `FPCS_CLK_NS
) (
    input  wire        CLK,           // 200 MHz clock
    input  wire        RST_N,         // Synchronous reset, active low
    input  wire [2:0]  AVS_ADDRESS,   // Avalon word address
    input  wire        AVS_READ,      // Avalon read
    input  wire        AVS_WRITE,     // Avalon write
    input  wire [31:0] AVS_WRITEDATA, // Avalon write data
    output reg  [31:0] AVS_READDATA,  // Avalon read data
    output wire        AVS_WAITREQUEST, // Avalon wait
    output reg  [22:0] FL_ADDR,       // Flash address
    output reg  [15:0] FL_DQ_OUT,     // Flash data out
    output reg         FL_DQ_OE_N,    // Flash data drive, low drives
    input  wire [15:0] FL_DQ_IN,      // Flash data in
    output reg         FL_WE_N,       // Flash write strobe
    output reg         FL_OE_N,       // Flash output strobe
    output reg         FL_CE_N,       // Flash chip enable
    input  wire        FL_READY_BUSY  // Ready/busy line after pull-up
);
    localparam [31:0] PWD_WAIT_CYC = (`FPCS_PWD_WAIT_NS + `FPCS_CLK_NS - 1) / `FPCS_CLK_NS;
    // Sized copy, so the wait load below is a deliberate part-select
    localparam [31:0] LOCK_WAIT_32 = LOCK_WAIT_CYC;
    // Exit steps issued before a lock program retry
    localparam STEP_EXIT     = 4'h6;
    localparam STEP_EXIT_END = 4'h9;

    localparam S_IDLE  = 3'h0;
    localparam S_WR    = 3'h1;
    localparam S_RD    = 3'h2;
    localparam S_WAIT  = 3'h3;
    localparam S_NEXT  = 3'h4;
    localparam S_DONE  = 3'h5;

    reg [2:0]  state;
    reg [3:0]  cmd;
    reg [22:0] base_addr;
    reg [15:0] wdata;
    reg [3:0]  step;
    reg [3:0]  phase;
    reg [24:0] wait_cnt;
    reg [7:0]  tries;
    reg        busy;
    reg        fail;
    reg        done;
    reg [15:0] rdata;
    reg [15:0] prev_rd;
    reg        have_prev;
    reg        timeout_seen;
    // High in the second cycle of a read, when read data stands
    reg        rd_ready;

    // Cycle table for the current step
    reg        c_wr;
    reg        c_last;
    reg [22:0] c_addr;
    reg [7:0]  c_data;
    reg [24:0] c_wait;
    reg [22:0] lock_addr;

    // Read data is registered: one wait cycle lets it stand at the
    // edge where the master sees waitrequest low; writes never wait
    assign AVS_WAITREQUEST = AVS_READ && !rd_ready;

    always @* begin
        lock_addr = base_addr;
        c_wr = 1'b1;
        c_last = 1'b0;
        c_wait = 25'h0;
        c_addr = {11'h0, `FPCS_UNLOCK_A1};
        c_data = `FPCS_UNLOCK_D1;
        if (step == 4'h1) begin // see R3
            c_addr = {11'h0, `FPCS_UNLOCK_A2};
            c_data = `FPCS_UNLOCK_D2;
        end
        case (cmd)
        `FPCS_CMD_LOCK_PROG: begin
            // Low byte picks which lock bit (see R1) (see R2)
            case (step)
            4'h2: c_data = `FPCS_OP_LOCK;
            4'h3: begin
                c_addr = lock_addr;
                c_data = `FPCS_OP_LOCK_PROG;
                c_wait = LOCK_WAIT_32[24:0]; // see R5
            end
            4'h4: begin
                c_addr = lock_addr;
                c_data = `FPCS_OP_LOCK_VFY;
            end
            4'h5: begin
                c_addr = lock_addr;
                c_wr = 1'b0;
                c_last = 1'b1;
            end
            // Exit before a retry; step 6 is the default opener (see R11)
            4'h7: begin
                c_addr = {11'h0, `FPCS_UNLOCK_A2};
                c_data = `FPCS_UNLOCK_D2;
            end
            4'h8: c_data = `FPCS_OP_IDQUERY;
            STEP_EXIT_END: c_data = `FPCS_OP_RESET;
            default: ;
            endcase
        end
        `FPCS_CMD_LOCK_ERASE: begin
            case (step)
            4'h2: c_data = `FPCS_OP_LOCK;
            4'h3: begin
                c_addr = {base_addr[22:8], `FPCS_LOC_SECTOR};
                c_data = `FPCS_OP_LOCK_ERA;
                c_wait = LOCK_WAIT_32[24:0];
            end
            4'h4: begin
                c_addr = base_addr;
                c_data = `FPCS_OP_ERA_VFY;
            end
            4'h5: begin
                c_addr = {base_addr[22:8], `FPCS_LOC_SECTOR};
                c_wr = 1'b0;
                c_last = 1'b1;
            end
            default: ;
            endcase
        end
        `FPCS_CMD_PWD_PROG: begin
            case (step)
            4'h2: c_data = `FPCS_OP_PWD_PROG;
            4'h3: begin
                c_addr = {21'h0, base_addr[1:0]}; // see R7
                c_data = wdata[7:0];
                c_wait = PWD_WAIT_CYC[24:0]; // see R6
                c_last = 1'b1;
            end
            default: ;
            endcase
        end
        `FPCS_CMD_LOCK_STATUS: begin
            case (step)
            4'h2: c_data = `FPCS_OP_LBS;
            4'h3: begin
                c_addr = base_addr;
                c_wr = 1'b0;
                c_last = 1'b1;
            end
            default: ;
            endcase
        end
        `FPCS_CMD_RESET: begin
            // ID query opener then reset (see R11)
            case (step)
            4'h2: c_data = `FPCS_OP_IDQUERY;
            4'h3: begin
                c_data = `FPCS_OP_RESET;
                c_last = 1'b1;
            end
            default: ;
            endcase
        end
        `FPCS_CMD_WRITE: begin
            c_addr = base_addr;
            c_data = wdata[7:0];
            c_last = 1'b1;
        end
        default: begin
            // Single read, also used for status polling
            c_addr = base_addr;
            c_wr = 1'b0;
            c_last = 1'b1;
        end
        endcase
    end

    always @(posedge CLK) begin
        if (!RST_N) begin
            state <= S_IDLE;
            cmd <= 4'h0;
            base_addr <= 23'h0;
            wdata <= 16'h0;
            step <= 4'h0;
            phase <= 4'h0;
            wait_cnt <= 25'h0;
            tries <= 8'h0;
            busy <= 1'b0;
            fail <= 1'b0;
            done <= 1'b0;
            rdata <= 16'h0;
            prev_rd <= 16'h0;
            have_prev <= 1'b0;
            timeout_seen <= 1'b0;
            FL_ADDR <= 23'h0;
            FL_DQ_OUT <= 16'h0;
            FL_DQ_OE_N <= 1'b1;
            FL_WE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            FL_CE_N <= 1'b1;
            AVS_READDATA <= 32'h0;
            rd_ready <= 1'b0;
        end else begin
            // Alternates so every read gets exactly one wait cycle
            rd_ready <= AVS_READ && !rd_ready;
            if (AVS_READ) begin
                case (AVS_ADDRESS)
                `FPCS_REG_CTRL:   AVS_READDATA <= {28'h0, cmd};
                `FPCS_REG_ADDR:   AVS_READDATA <= {9'h0, base_addr};
                `FPCS_REG_DATA:   AVS_READDATA <= {16'h0, wdata};
                `FPCS_REG_STATUS: AVS_READDATA <= {20'h0, tries, 1'b0, fail, done, busy};
                `FPCS_REG_RDATA:  AVS_READDATA <= {16'h0, rdata};
                default:          AVS_READDATA <= 32'h0;
                endcase
            end
            if (AVS_WRITE && AVS_ADDRESS == `FPCS_REG_ADDR && !busy)
                base_addr <= AVS_WRITEDATA[22:0];
            if (AVS_WRITE && AVS_ADDRESS == `FPCS_REG_DATA && !busy)
                wdata <= AVS_WRITEDATA[15:0];
            case (state)
            S_IDLE: begin
                // New orders only while idle (see R24)
                if (AVS_WRITE && AVS_ADDRESS == `FPCS_REG_CTRL &&
                    AVS_WRITEDATA[`FPCS_CTRL_GO]) begin
                    cmd <= AVS_WRITEDATA[3:0];
                    step <= 4'h0;
                    phase <= 4'h0;
                    tries <= 8'h0;
                    busy <= 1'b1;
                    done <= 1'b0;
                    fail <= 1'b0;
                    have_prev <= 1'b0;
                    timeout_seen <= 1'b0;
                    state <= (AVS_WRITEDATA[3:0] == `FPCS_CMD_WRITE ||
                              AVS_WRITEDATA[3:0] <= `FPCS_CMD_LOCK_STATUS ||
                              AVS_WRITEDATA[3:0] == `FPCS_CMD_RESET) ? S_WR : S_RD;
                end
            end
            S_WR, S_RD: begin
                // Strobe held STROBE_CYC cycles; rising edge latches data
                FL_ADDR <= c_addr;
                FL_CE_N <= 1'b0;
                FL_DQ_OUT <= {8'h0, c_data};
                FL_DQ_OE_N <= !c_wr;
                phase <= phase + 4'h1;
                if (phase == 4'h0) begin
                    FL_WE_N <= !c_wr;
                    FL_OE_N <= c_wr;
                end else if (phase == `FPCS_STROBE_CYC) begin
                    FL_WE_N <= 1'b1;
                    FL_OE_N <= 1'b1;
                    FL_DQ_OE_N <= 1'b1;
                    if (!c_wr)
                        rdata <= FL_DQ_IN;
                    phase <= 4'h0;
                    wait_cnt <= c_wait;
                    state <= S_WAIT;
                end
            end
            S_WAIT: begin
                FL_CE_N <= 1'b1;
                if (wait_cnt != 25'h0)
                    wait_cnt <= wait_cnt - 25'h1;
                else
                    state <= S_NEXT;
            end
            S_NEXT: begin
                if (!c_last) begin
                    // Exit steps wrap back to a fresh sequence
                    step <= (step == STEP_EXIT_END) ? 4'h0 : step + 4'h1;
                    state <= c_wr ? S_WR : S_RD;
                end else if (cmd == `FPCS_CMD_LOCK_PROG &&
                             !rdata[`FPCS_BIT_LOWEST]) begin // see R4
                    tries <= tries + 8'h1;
                    step <= STEP_EXIT; // see R11
                    fail <= (tries == `FPCS_MAX_TRIES);
                    state <= (tries == `FPCS_MAX_TRIES) ? S_DONE : S_WR;
                end else if (cmd == `FPCS_CMD_LOCK_ERASE &&
                             rdata[`FPCS_BIT_LOWEST]) begin // see R9
                    tries <= tries + 8'h1;
                    step <= 4'h0;
                    fail <= (tries == `FPCS_MAX_TRIES);
                    state <= (tries == `FPCS_MAX_TRIES) ? S_DONE : S_WR;
                end else if (cmd == `FPCS_CMD_POLL) begin
                    // Toggle compare; a read after the stop gives true data
                    // (see R18) (see R16) (see R22)
                    prev_rd <= rdata;
                    have_prev <= 1'b1;
                    if (rdata[`FPCS_BIT_TIMEOUT])
                        timeout_seen <= 1'b1;
                    if (have_prev && prev_rd[`FPCS_BIT_TOGGLE] == rdata[`FPCS_BIT_TOGGLE]
                        && FL_READY_BUSY) begin // see R17
                        state <= S_DONE;
                    end else if (have_prev && timeout_seen) begin
                        // Recheck after timeout, still toggling: fail
                        // (see R21) (see R23)
                        fail <= 1'b1;
                        cmd <= `FPCS_CMD_RESET;
                        // Reset command alone returns the bank to reads
                        step <= 4'h3;
                        state <= S_WR;
                    end else begin
                        state <= S_RD;
                    end
                end else begin
                    state <= S_DONE;
                end
            end
            S_DONE: begin
                busy <= 1'b0;
                done <= 1'b1;
                state <= S_IDLE;
            end
            default: state <= S_IDLE;
            endcase
        end
    end
endmodule // fpcs_host

// ==== tb/fpcs_host_chk.sv ====
// Checker of the host controller's flash strobes and bus answers
`timescale 1ns/1ps
module fpcs_host_chk #(
    parameter LOCK_WAIT_CYC = 4
) (
    input wire logic        CLK,             // Clock
    input wire logic        RST_N,           // Reset, active low
    input wire logic        AVS_WAITREQUEST, // Avalon wait
    input wire logic [31:0] AVS_READDATA,    // Avalon read data
    input wire logic [22:0] FL_ADDR,         // Flash address
    input wire logic [15:0] FL_DQ_OUT,       // Flash data out
    input wire logic        FL_DQ_OE_N,      // Data drive, low drives
    input wire logic        FL_WE_N,         // Write strobe
    input wire logic        FL_OE_N,         // Output strobe
    input wire logic        FL_CE_N          // Chip enable
);
    logic [31:0] gap;
    logic [7:0]  last_d;
    // Gap counts idle cycles since the last write strobe
    always @(posedge CLK) begin
        if (!RST_N) begin
            gap    <= 32'h0;
            last_d <= 8'h00;
        end else if (!FL_WE_N) begin
            gap    <= 32'h0;
            last_d <= FL_DQ_OUT[7:0];
        end else begin
            gap <= gap + 32'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence s_strobe_low;
        (!FL_WE_N)[*4];
    endsequence
    chk_idle_reset: assert property ($rose(RST_N) |-> FL_WE_N && FL_OE_N && FL_CE_N
        && AVS_READDATA == 32'h0) else $error("flash strobes or read data not idle after reset");
    chk_wait_short: assert property (AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
        else $error("waitrequest held more than one cycle");
    chk_one_strobe: assert property (!(!FL_WE_N && !FL_OE_N))
        else $error("write and output strobes low together");
    chk_write_drive: assert property (!FL_WE_N |-> !FL_CE_N && !FL_DQ_OE_N)
        else $error("write strobe without chip enable or data drive");
    chk_read_float: assert property (!FL_OE_N |-> FL_DQ_OE_N && !FL_CE_N)
        else $error("host drives data during a read");
    chk_strobe_width: assert property ($fell(FL_WE_N) |-> s_strobe_low ##[0:2] FL_WE_N)
        else $error("write strobe width wrong");
    chk_write_hold: assert property (!FL_WE_N && $past(!FL_WE_N) |->
        $stable(FL_ADDR) && $stable(FL_DQ_OUT[7:0])) else $error("address or data moved in strobe");
    chk_verify_wait: assert property ($fell(FL_WE_N) && last_d == 8'h68 |->
        gap >= LOCK_WAIT_CYC) else $error("verify cycle too soon after lock program");
    chk_unlock_pair: assert property ($fell(FL_WE_N) && last_d == 8'hAA |->
        FL_ADDR[11:0] == 12'h2AA && FL_DQ_OUT[7:0] == 8'h55) else $error("second unlock wrong");
endmodule // fpcs_host_chk

bind fpcs_host fpcs_host_chk #(.LOCK_WAIT_CYC(LOCK_WAIT_CYC)) u_chk (.CLK(CLK), .RST_N(RST_N),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .AVS_READDATA(AVS_READDATA), .FL_ADDR(FL_ADDR),
    .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE_N(FL_DQ_OE_N), .FL_WE_N(FL_WE_N), .FL_OE_N(FL_OE_N),
    .FL_CE_N(FL_CE_N));

// ==== tb/fpcs_flash_model.sv ====
// Behavioural flash answering protection commands and status reads
`timescale 1ns/1ps
module fpcs_flash_model #(
    parameter LOCK_WAIT = 40,
    parameter PWD_WAIT  = 400,
    parameter BUSY      = 20
) (
    input  wire logic        CLK,       // Clock
    input  wire logic        RST_N,     // Reset, active low
    input  wire logic [22:0] FL_ADDR,   // Address from host
    input  wire logic [15:0] FL_DQ_OUT, // Data from host
    input  wire logic        FL_WE_N,   // Write strobe
    input  wire logic        FL_OE_N,   // Output strobe
    input  wire logic        FL_CE_N,   // Chip enable
    input  wire logic        INJ_FAIL,  // Verify reads wrong while high
    input  wire logic        FROZEN,    // Persistent locks frozen
    output logic             DRV,       // Model drives data
    output logic [15:0]      RD,        // Data from model
    output logic             RB         // Ready/busy level
);
    logic [31:0] cyc, t4, tpw;
    logic [7:0]  busy_cnt, viol, nprog, nrst, cmd, ld;
    logic [7:0]  pw [0:3];
    logic [22:0] la;
    logic [3:0]  lk;
    logic [1:0]  step, mode, li;
    logic        we_q, oe_q, need_exit, tgl, ers;
    assign li = (la[7:0] == 8'h1A) ? 2'h0 : (la[7:0] == 8'h0A) ? 2'h1 :
                (la[7:0] == 8'h12) ? 2'h2 : 2'h3;
    assign DRV = !FL_CE_N && !FL_OE_N;
    assign RB  = (busy_cnt == 8'h00);
    always @* begin
        if (busy_cnt != 8'h00)
            RD = {8'h00, ers ? 1'b0 : ~ld[7], tgl, 6'h00};
        else if (mode == 2'h1)
            RD = {15'h0000, lk[li] ^ INJ_FAIL};
        else if (mode == 2'h2)
            RD = {14'h0000, FROZEN, 1'b0};
        else if (mode == 2'h3)
            RD = lk[1] ? 16'hFFFF : {8'h00, pw[FL_ADDR[1:0]]};
        else
            RD = {FL_ADDR[7:0], ~FL_ADDR[7:0]};
    end
    always @(posedge CLK) begin
        if (!RST_N) begin
            {busy_cnt, viol, nprog, nrst, step, mode, need_exit, we_q, lk} <= '0;
            tgl <= 1'b0;
            oe_q <= 1'b1;
            tpw <= 32'h0;
            cyc <= 32'h0;
        end else begin
            cyc  <= cyc + 32'h1;
            we_q <= FL_WE_N;
            oe_q <= FL_OE_N;
            // One toggle per read while busy; no suspend, so busy alone rules
            if (!FL_OE_N && oe_q && busy_cnt != 8'h00) tgl <= ~tgl;
            if (busy_cnt != 8'h00) busy_cnt <= busy_cnt - 8'h01;
            if (!FL_WE_N) begin
                la <= FL_ADDR;
                ld <= FL_DQ_OUT[7:0];
            end
            // Writes while busy are dropped
            if (FL_WE_N && !we_q && busy_cnt == 8'h00) begin
                if (ld == 8'hF0) begin
                    if (need_exit && cmd != 8'h90) viol <= viol + 8'h01;
                    {need_exit, step, mode} <= '0;
                    nrst <= nrst + 8'h01;
                end else if (step == 2'h0) begin
                    step <= (la[11:0] == 12'h555 && ld == 8'hAA) ? 2'h1 : 2'h0;
                end else if (step == 2'h1) begin
                    step <= (la[11:0] == 12'h2AA && ld == 8'h55) ? 2'h2 : 2'h0;
                end else if (step == 2'h2) begin
                    cmd  <= ld;
                    step <= 2'h3;
                    mode <= (ld == 8'h58) ? 2'h2 : (ld == 8'hC8) ? 2'h3 : 2'h0;
                    if (need_exit && ld != 8'h90) viol <= viol + 8'h01;
                end else if (la[11:0] == 12'h555 && ld == 8'hAA) begin
                    step <= 2'h1; // A new unlock restarts decoding
                end else if (cmd == 8'h60 && (ld == 8'h68 || ld == 8'h60)) begin
                    if (ld == 8'h68) lk[li] <= 1'b1;
                    else lk[3] <= 1'b0;
                    nprog     <= nprog + {7'h00, ld == 8'h68};
                    need_exit <= need_exit | (ld == 8'h68);
                    ers       <= (ld == 8'h60);
                    busy_cnt  <= BUSY;
                    t4        <= cyc;
                end else if (cmd == 8'h60 && (ld == 8'h48 || ld == 8'h40)) begin
                    if (ld == 8'h48 && cyc - t4 < LOCK_WAIT) viol <= viol + 8'h01;
                    mode <= 2'h1;
                end else if (cmd == 8'h38) begin
                    pw[la[1:0]] <= ld;
                    if (cyc - tpw < PWD_WAIT) viol <= viol + 8'h01;
                    tpw      <= cyc;
                    ers      <= 1'b0;
                    busy_cnt <= BUSY;
                end
            end
        end
    end
endmodule // fpcs_flash_model

// ==== tb/fpcs_host_tb_top.sv ====
// Testbench driving the host controller over Avalon against the flash model
`timescale 1ns/1ps
`include "fpcs_defines.vh"
module fpcs_host_tb_top;
    logic        clk, rst_n, av_rd_s, av_wr_s, inj, frozen, fl_drv, rb;
    logic        av_wait, dq_oe_n, we_n, oe_n, ce_n;
    logic [2:0]  av_addr;
    logic [31:0] av_wdata, av_rdata, st;
    logic [22:0] fl_addr;
    logic [15:0] dq_out, dq_in, fl_rd;
    logic [15:0] dq_last = 16'h0000;
    logic [7:0]  locs [0:3];
    int          num_errors, n_checks, i, n;
    int          cycles = 0;
    // Released bus shows the inverse of its last level
    assign dq_in = !dq_oe_n ? dq_out : fl_drv ? fl_rd : ~dq_last;
    always @(posedge clk) dq_last <= dq_in;
    fpcs_host #(.LOCK_WAIT_CYC(40)) u_dut (.CLK(clk), .RST_N(rst_n), .AVS_ADDRESS(av_addr),
        .AVS_READ(av_rd_s), .AVS_WRITE(av_wr_s), .AVS_WRITEDATA(av_wdata),
        .AVS_READDATA(av_rdata), .AVS_WAITREQUEST(av_wait), .FL_ADDR(fl_addr),
        .FL_DQ_OUT(dq_out), .FL_DQ_OE_N(dq_oe_n), .FL_DQ_IN(dq_in), .FL_WE_N(we_n),
        .FL_OE_N(oe_n), .FL_CE_N(ce_n), .FL_READY_BUSY(rb));
    fpcs_flash_model #(.LOCK_WAIT(40), .PWD_WAIT(400), .BUSY(20)) u_flash (.CLK(clk),
        .RST_N(rst_n), .FL_ADDR(fl_addr), .FL_DQ_OUT(dq_out), .FL_WE_N(we_n), .FL_OE_N(oe_n),
        .FL_CE_N(ce_n), .INJ_FAIL(inj), .FROZEN(frozen), .DRV(fl_drv), .RD(fl_rd), .RB(rb));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic av_wr(input logic [2:0] a, input logic [31:0] d);
        @(posedge clk);
        av_addr  <= a;
        av_wdata <= d;
        av_wr_s  <= 1'b1;
        do @(posedge clk); while (av_wait !== 1'b0);
        av_wr_s <= 1'b0;
    endtask
    // Read data is taken at the edge where waitrequest is seen low
    task automatic av_rd(input logic [2:0] a);
        @(posedge clk);
        av_addr <= a;
        av_rd_s <= 1'b1;
        do @(posedge clk); while (av_wait !== 1'b0);
        st = av_rdata;
        av_rd_s <= 1'b0;
    endtask
    task automatic run_cmd(input logic [3:0] c, input logic [22:0] a, input logic [7:0] d);
        av_wr(`FPCS_REG_ADDR, {9'h000, a});
        av_wr(`FPCS_REG_DATA, {24'h000000, d});
        av_wr(`FPCS_REG_CTRL, {27'h0000001, c});
        do av_rd(`FPCS_REG_STATUS); while (!(st[0] === 1'b0 && st[1] === 1'b1));
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            $display("[ERR] %0t run timed out", $time);
            tally_and_finish;
        end
    end
    initial begin
        {rst_n, av_rd_s, av_wr_s, inj, frozen} = '0;
        av_addr = 3'h0;
        av_wdata = 32'h0;
        num_errors = 0;
        n_checks = 0;
        locs = '{8'h1A, 8'h0A, 8'h12, 8'h02};
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        av_rd(`FPCS_REG_STATUS);
        check(st & 32'h7, 32'h0, "status after reset");
        $display("test reset done");
        for (i = 0; i < 4; i++) begin
            n = u_flash.nprog;
            run_cmd(`FPCS_CMD_LOCK_PROG, {15'h0003, locs[i]}, 8'h00);
            check(st & 32'h4, 32'h0, "lock program fail flag");
            check({31'h0, u_flash.lk[i]}, 32'h1, "lock bit set");
            check({24'h0, u_flash.nprog}, 32'(n + 1), "program count");
            run_cmd(`FPCS_CMD_RESET, 23'h0, 8'h00);
        end
        check({24'h0, u_flash.nrst}, 32'h4, "exit resets");
        $display("test lock program done");
        n = u_flash.nprog;
        inj <= 1'b1;
        fork
            run_cmd(`FPCS_CMD_LOCK_PROG, 23'h000302, 8'h00);
            begin
                wait (u_flash.nprog == 8'(n + 2));
                @(posedge clk) inj <= 1'b0;
            end
        join
        check({24'h0, u_flash.nprog}, 32'(n + 2), "program repeated");
        check(st & 32'h4, 32'h0, "retry fail flag");
        run_cmd(`FPCS_CMD_RESET, 23'h0, 8'h00);
        $display("test retry done");
        run_cmd(`FPCS_CMD_LOCK_ERASE, 23'h000302, 8'h00);
        check(st & 32'h4, 32'h0, "erase fail flag");
        check({31'h0, u_flash.lk[3]}, 32'h0, "sector locks erased");
        $display("test erase done");
        for (i = 0; i < 4; i++) begin
            run_cmd(`FPCS_CMD_PWD_PROG, 23'(i), 8'h31 + 8'(i));
            check({24'h0, u_flash.pw[i]}, 32'h31 + i, "password portion");
        end
        $display("test password done");
        for (i = 0; i < 2; i++) begin
            frozen <= i[0];
            run_cmd(`FPCS_CMD_LOCK_STATUS, 23'h000302, 8'h00);
            av_rd(`FPCS_REG_RDATA);
            check(st & 32'h2, 32'(i * 2), "lock status bit");
        end
        run_cmd(`FPCS_CMD_WRITE, 23'h000555, 8'hAA);
        run_cmd(`FPCS_CMD_WRITE, 23'h0002AA, 8'h55);
        run_cmd(`FPCS_CMD_WRITE, 23'h000555, 8'hC8);
        run_cmd(`FPCS_CMD_READ, 23'h000000, 8'h00);
        av_rd(`FPCS_REG_RDATA);
        check(st & 32'hFF, 32'hFF, "locked password verify");
        run_cmd(`FPCS_CMD_RESET, 23'h0, 8'h00);
        run_cmd(`FPCS_CMD_READ, 23'h001234, 8'h00);
        av_rd(`FPCS_REG_RDATA);
        check(st & 32'hFFFF, 32'h34CB, "raw array read");
        run_cmd(`FPCS_CMD_POLL, 23'h000055, 8'h00);
        check(st & 32'h4, 32'h0, "poll fail flag");
        av_rd(`FPCS_REG_RDATA);
        check(st & 32'hFFFF, 32'h55AA, "poll true data");
        check({24'h0, u_flash.viol}, 32'h0, "host timing and order");
        $display("test status and read done");
        tally_and_finish;
    end
endmodule // fpcs_host_tb_top
